/* File: logic/tsc_defines.svh */
// Constants of the switch control register block: offsets, fields, reset values.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

`define TSC_CTRL_OFFSET      5'h00
`define TSC_MEM_SPACE_BIT    5
`define TSC_CTRL_RESET       8'h00
`define TSC_SPLIT_BIT        7
`define TSC_MSG_ALL_BIT      6
`define TSC_STREAM_MSB_BIT   5
`define TSC_MSEL_HI          4
`define TSC_MSEL_LO          3
`define TSC_STREAM_LOW_HI    2
`define TSC_CMH_OE_BIT       0
`define TSC_CMH_MSG_BIT      2

`endif

/* File: logic/tsc_pkg.sv */
// Types shared by the switch control register block.
// Assumes tsc_defines.svh is reachable on the include path.
`default_nettype none
`include "tsc_defines.svh"

package tsc_pkg;

    typedef enum logic [1:0] {
        TSC_MEM_NONE = 2'h0,
        TSC_MEM_DATA = 2'h1,
        TSC_MEM_CML  = 2'h2,
        TSC_MEM_CMH  = 2'h3
    } tsc_mem_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        tsc_mem_type target;
        logic [3:0]  stream;
        logic [6:0]  channel;
        logic [7:0]  wdata;
    } tsc_mem_req_type;

    typedef enum logic [1:0] {
        TSC_IDLE   = 2'b00,
        TSC_ACCESS = 2'b01,
        TSC_HOLD   = 2'b11
    } tsc_state_type;

endpackage
`default_nettype wire

/* File: logic/tsc_switch_control.sv */
// Switch control register, microport front end and per-channel output drive logic.
// Assumes microport pins are asynchronous; memories answer one clock after a request.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.svh"

module tsc_switch_control (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     up_cs_n_i,
    input  wire logic                     up_ds_n_i,
    input  wire logic                     up_read_i,
    input  wire logic [7:0]               up_addr_i,
    input  wire logic [7:0]               up_data_i,
    output logic      [7:0]               up_data_o,
    output logic                          up_data_oe_n_o,
    output logic                          up_ack_n_o,
    input  wire logic                     cfg_16x8_i,
    output tsc_pkg::tsc_mem_req_type      mem_req_o,
    input  wire logic [7:0]               mem_rdata_i,
    input  wire logic                     global_output_drive_enable_i,
    input  wire logic [7:0]               chan_cmh_i,
    input  wire logic [7:0]               chan_cml_i,
    input  wire logic [7:0]               chan_switched_i,
    output logic      [7:0]               ser_byte_o,
    output logic                          ser_drive_n_o,
    output logic      [7:0]               switch_control_o
);

    localparam int SYNC_W = 20;

    logic [SYNC_W-1:0]       sync1_reg;
    logic [SYNC_W-1:0]       sync2_reg;
    logic                    strobe_q_reg;
    logic [7:0]              ctrl_reg;
    tsc_pkg::tsc_state_type  state_reg;
    tsc_pkg::tsc_state_type  state_next;
    tsc_pkg::tsc_mem_req_type req_reg;
    logic [7:0]              rdata_reg;
    logic                    rd_pending_reg;
    logic [7:0]              ser_byte_reg;
    logic                    ser_drive_n_reg;

    // Two-stage synchronisers for the microport pins and the output drive enable pin
    always_ff @(posedge core_clk_i) begin
        sync1_reg <= {global_output_drive_enable_i, up_cs_n_i, up_ds_n_i, up_read_i, up_addr_i, up_data_i};
        sync2_reg <= sync1_reg;
    end

    wire logic [7:0] s_data   = sync2_reg[7:0];
    wire logic [7:0] s_addr   = sync2_reg[15:8];
    wire logic       s_read   = sync2_reg[16];
    wire logic       s_strobe = ~sync2_reg[17] & ~sync2_reg[18];
    wire logic       s_ode    = sync2_reg[19];
    wire logic       start    = s_strobe & ~strobe_q_reg;

    wire logic       is_mem   = s_addr[`TSC_MEM_SPACE_BIT];
    wire logic       is_ctrl  = ~is_mem & (s_addr[4:0] == `TSC_CTRL_OFFSET);
    wire logic       split    = ctrl_reg[`TSC_SPLIT_BIT];
    wire logic       msg_all  = ctrl_reg[`TSC_MSG_ALL_BIT];
    wire logic [1:0] msel     = ctrl_reg[`TSC_MSEL_HI:`TSC_MSEL_LO];

    // Split mode overrides the select field by direction
    wire tsc_pkg::tsc_mem_type target =
        split ? (s_read ? tsc_pkg::TSC_MEM_DATA : tsc_pkg::TSC_MEM_CML) : tsc_pkg::tsc_mem_type'(msel);
    // Data memory is read only and code 00 reaches nothing
    wire logic mem_ok = (target != tsc_pkg::TSC_MEM_NONE) &&
                        !(target == tsc_pkg::TSC_MEM_DATA && !s_read);
    wire logic stream_msb = cfg_16x8_i && (target == tsc_pkg::TSC_MEM_DATA) &&
                            ctrl_reg[`TSC_STREAM_MSB_BIT];
    wire logic [3:0] stream = {stream_msb, ctrl_reg[`TSC_STREAM_LOW_HI:0]};
    wire logic [6:0] channel = {s_addr[7:6], s_addr[4:0]};
    wire logic       mem_go  = start && (state_reg == tsc_pkg::TSC_IDLE) && is_mem && mem_ok;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tsc_pkg::TSC_IDLE: begin
                if (start) begin
                    state_next = (is_mem && mem_ok && s_read) ? tsc_pkg::TSC_ACCESS : tsc_pkg::TSC_HOLD;
                end
            end
            // Wait for the memory answer so acknowledge never precedes data
            tsc_pkg::TSC_ACCESS: begin
                if (rd_pending_reg) begin
                    state_next = tsc_pkg::TSC_HOLD;
                end
            end
            tsc_pkg::TSC_HOLD: begin
                if (!s_strobe) begin
                    state_next = tsc_pkg::TSC_IDLE;
                end
            end
            default: state_next = tsc_pkg::TSC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_reg    <= tsc_pkg::TSC_IDLE;
            strobe_q_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            strobe_q_reg <= s_strobe;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `TSC_CTRL_RESET;
        end else if (start && state_reg == tsc_pkg::TSC_IDLE && is_ctrl && !s_read) begin
            ctrl_reg <= s_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            req_reg <= '0;
        end else begin
            req_reg.valid <= mem_go;
            // Fields stand from one accepted access to the next
            if (mem_go) begin
                req_reg.write   <= ~s_read;
                req_reg.target  <= target;
                req_reg.stream  <= stream;
                req_reg.channel <= channel;
                req_reg.wdata   <= s_data;
            end
        end
    end

    // Read data: register copy for control, memory answer one cycle after request
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg      <= 8'h00;
            rd_pending_reg <= 1'b0;
        end else begin
            rd_pending_reg <= req_reg.valid & ~req_reg.write;
            if (start && state_reg == tsc_pkg::TSC_IDLE) begin
                rdata_reg <= is_ctrl ? ctrl_reg : 8'h00;
            end else if (rd_pending_reg) begin
                rdata_reg <= mem_rdata_i;
            end
        end
    end

    // Per-channel drive: connection memory high is unreset, so the pin gates all
    wire logic chan_msg = msg_all | chan_cmh_i[`TSC_CMH_MSG_BIT];
    wire logic chan_oe  = msg_all | chan_cmh_i[`TSC_CMH_OE_BIT];
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ser_byte_reg    <= 8'h00;
            ser_drive_n_reg <= 1'b1;
        end else begin
            ser_byte_reg    <= chan_msg ? chan_cml_i : chan_switched_i;
            ser_drive_n_reg <= ~(s_ode & chan_oe);
        end
    end

    wire logic hold_read = (state_reg == tsc_pkg::TSC_HOLD) && s_read && s_strobe;
    assign up_data_o        = rdata_reg;
    assign up_data_oe_n_o   = ~hold_read;
    assign up_ack_n_o       = ~(state_reg == tsc_pkg::TSC_HOLD && s_strobe);
    assign mem_req_o        = req_reg;
    assign ser_byte_o       = ser_byte_reg;
    assign ser_drive_n_o    = ser_drive_n_reg;
    assign switch_control_o = ctrl_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_mem_start;
        start && state_reg == tsc_pkg::TSC_IDLE && is_mem;
    endsequence

    sequence s_read_start;
        s_mem_start ##0 mem_ok && s_read;
    endsequence

    // Channel output checks

    a_ode_low_floats: assert property (!s_ode |=> ser_drive_n_o)
        else $error("output driven while drive enable low");
    a_msg_all_drives: assert property (s_ode && msg_all |=> !ser_drive_n_o)
        else $error("message-all did not enable driver");
    a_msg_all_byte: assert property (msg_all |=> ser_byte_o == $past(chan_cml_i))
        else $error("message-all did not output low byte");
    a_chan_enable: assert property (s_ode && !msg_all |=>
        ser_drive_n_o == !$past(chan_cmh_i[`TSC_CMH_OE_BIT]))
        else $error("driver does not follow channel enable bit");
    a_switched_byte: assert property (!msg_all && !chan_cmh_i[`TSC_CMH_MSG_BIT] |=>
        ser_byte_o == $past(chan_switched_i))
        else $error("switched byte not output");

    // Microport access checks
    a_no_data_write: assert property (req_reg.valid |-> !(req_reg.write && req_reg.target == tsc_pkg::TSC_MEM_DATA))
        else $error("write reached data memory");
    a_no_code_zero: assert property (req_reg.valid |-> req_reg.target != tsc_pkg::TSC_MEM_NONE)
        else $error("access with unused select code");
    a_split_route: assert property (s_mem_start ##0 split |=> req_reg.valid &&
        req_reg.target == (req_reg.write ? tsc_pkg::TSC_MEM_CML : tsc_pkg::TSC_MEM_DATA))
        else $error("split mode routed wrongly");
    a_stream_low: assert property (s_mem_start ##0 mem_ok |=> req_reg.stream[2:0] == $past(ctrl_reg[2:0]))
        else $error("stream select not applied");
    a_stream_msb: assert property (req_reg.valid && req_reg.stream[3] |->
        req_reg.target == tsc_pkg::TSC_MEM_DATA && $past(cfg_16x8_i))
        else $error("stream msb used outside sixteen-by-eight data access");
    a_msb_forward: assert property (s_mem_start ##0 mem_ok && cfg_16x8_i &&
        target == tsc_pkg::TSC_MEM_DATA && ctrl_reg[`TSC_STREAM_MSB_BIT] |=> req_reg.stream[3])
        else $error("stream msb dropped on sixteen-by-eight data access");
    a_refused_none: assert property (s_mem_start ##0 !mem_ok |=> !req_reg.valid)
        else $error("refused access raised a memory request");
    a_ctrl_write: assert property (start && state_reg == tsc_pkg::TSC_IDLE && is_ctrl && !s_read |=>
        switch_control_o == $past(s_data))
        else $error("control register write lost");
    a_read_ack: assert property (s_read_start ##1 s_strobe [*3] |-> !up_ack_n_o)
        else $error("read not acknowledged");
    a_read_data: assert property (s_read_start ##1 s_strobe [*3] |-> up_data_o == $past(mem_rdata_i))
        else $error("acknowledged read data is not the memory answer");

endmodule // tsc_switch_control
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the switch control block.
// Assumes the host model and a one-cycle memory stand-in.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg = 1'b0;
    logic global_output_drive_enable = 1'b0;
    logic [7:0] mrd = 8'h00;
    logic [7:0] connection_memory_high = 8'h00;
    logic [7:0] ser, ctl, a, wd, q, rdat;
    logic cs_n, ds_n, rd, ack_n, drv_n, oe_n;
    int oe_cnt = 0;
    tsc_pkg::tsc_mem_req_type req;
    int err_count = 0;
    int check_count = 0;
    int vcnt = 0;
    tsc_switch_control u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .up_cs_n_i(cs_n), .up_ds_n_i(ds_n),
        .up_read_i(rd), .up_addr_i(a), .up_data_i(wd), .up_data_o(rdat), .up_data_oe_n_o(oe_n),
        .up_ack_n_o(ack_n), .cfg_16x8_i(cfg), .mem_req_o(req), .mem_rdata_i(mrd),
        .global_output_drive_enable_i(global_output_drive_enable), .chan_cmh_i(connection_memory_high), .chan_cml_i(8'hA5),
        .chan_switched_i(8'h3C), .ser_byte_o(ser), .ser_drive_n_o(drv_n), .switch_control_o(ctl));
    tsc_host_model u_host (.clk_i(clk), .ack_n_i(ack_n), .rdata_i(rdat), .cs_n_o(cs_n),
        .ds_n_o(ds_n), .rd_o(rd), .addr_o(a), .wdata_o(wd));
    initial begin
        forever #10 clk = ~clk;
    end
    // Cycles in which the block drives read data onto the microport
    always @(posedge clk) begin
        if (oe_n === 1'b0) oe_cnt++;
    end
    // Memory stand-in: the answer encodes target and stream
    always @(posedge clk) begin
        if (req.valid === 1'b1) begin
            mrd <= {req.target, req.stream, 2'h1};
            vcnt++;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdm(input logic [7:0] c);
        u_host.acc(1'b0, 8'h00, c, q);
        u_host.acc(1'b1, 8'h20, 8'h00, q);
    endtask
    task automatic t_sel();
        logic [7:0] c;
        int v;
        int o;
        for (int m = 0; m < 4; m++) begin
            c = {3'h0, m[1:0], 3'h5};
            v = vcnt;
            rdm(c);
            chk(ctl, c);
            chk(8'(vcnt - v), (m == 0) ? 8'h00 : 8'h01);
            if (m != 0) chk(q, {m[1:0], 4'h5, 2'h1});
            o = oe_cnt;
            u_host.acc(1'b1, 8'h00, 8'h00, q);
            chk(q, c);
            chk(8'(oe_cnt - o), 8'h03);
            v = vcnt;
            o = oe_cnt;
            u_host.acc(1'b0, 8'h24, 8'h77, q);
            chk(8'(vcnt - v), (m > 1) ? 8'h01 : 8'h00);
            chk(8'(oe_cnt - o), 8'h00);
            if (m > 1) chk({req.write, req.channel}, 8'h84);
            if (m > 1) chk(req.wdata, 8'h77);
        end
    endtask
    task automatic t_msb();
        cfg <= 1'b1;
        rdm(8'h2F);
        chk(q, 8'h7D);
        rdm(8'h37);
        chk(q, 8'h9D);
        cfg <= 1'b0;
        rdm(8'h2F);
        chk(q, 8'h5D);
    endtask
    task automatic t_split();
        rdm(8'h9B);
        chk(q, 8'h4D);
        u_host.acc(1'b0, 8'h20, 8'h11, q);
        chk({5'h0, req.write, req.target}, 8'h06);
        chk(req.wdata, 8'h11);
    endtask
    task automatic t_out();
        connection_memory_high <= 8'h01;
        repeat (4) @(posedge clk);
        chk({7'h0, drv_n}, 8'h01);
        global_output_drive_enable <= 1'b1;
        repeat (4) @(posedge clk);
        chk({7'h0, drv_n}, 8'h00);
        chk(ser, 8'h3C);
        connection_memory_high <= 8'h04;
        repeat (4) @(posedge clk);
        chk({7'h0, drv_n}, 8'h01);
        chk(ser, 8'hA5);
        connection_memory_high <= 8'h00;
        repeat (4) @(posedge clk);
        chk(ser, 8'h3C);
        chk({7'h0, drv_n}, 8'h01);
        u_host.acc(1'b0, 8'h00, 8'h40, q);
        chk({7'h0, drv_n}, 8'h00);
        chk(ser, 8'hA5);
        global_output_drive_enable <= 1'b0;
        repeat (4) @(posedge clk);
        chk({7'h0, drv_n}, 8'h01);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(ctl, 8'h00);
        chk({7'h0, drv_n}, 8'h01);
        t_sel();
        u_host.acc(1'b1, 8'h05, 8'h00, q);
        chk(q, 8'h00);
        t_msb();
        t_split();
        t_out();
        chk(8'(u_host.miss), 8'h00);
        results();
    end
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        results();
    end
endmodule // tb
`default_nettype wire

/* File: test/tsc_host_model.sv */
// Host processor model driving the microport of the switch control block.
// Assumes an active low acknowledge sampled on rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
    input  wire logic       clk_i,
    input  wire logic       ack_n_i,
    input  wire logic [7:0] rdata_i,
    output logic            cs_n_o,
    output logic            ds_n_o,
    output logic            rd_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    int miss = 0;
    initial begin
        {cs_n_o, ds_n_o, rd_o, addr_o, wdata_o} = 19'h70000;
    end
    // Call just after a rising edge; holds the request until acknowledged or for at most 17 rising edges
    task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        {rd_o, addr_o, wdata_o, cs_n_o, ds_n_o} <= {r, a, d, 2'h0};
        @(posedge clk_i);
        for (int n = 0; n < 16 && ack_n_i !== 1'b0; n++) @(posedge clk_i);
        if (ack_n_i !== 1'b0) miss++;
        q = rdata_i;
        {cs_n_o, ds_n_o, wdata_o} <= {2'h3, ~d};
        repeat (6) @(posedge clk_i);
    endtask
endmodule // tsc_host_model
`default_nettype wire
